// ---- design/pdc_regbank.sv ----
// Purpose: clock multiplier and converter control register bank
// Assumes: serial control port logic on clk_sys_in drives the access strobes
// Notes:   fields drive the analog periphery straight from flip-flops
//
// What this block does
// R1: multiplier register is three bytes at 0x04, bits drive periphery directly.
// R2: bits 23:21 read back oscillator voltage code; 011 means centred.
// R3: bits 20:16 set loop bandwidth; larger is lower; 01111 recommended.
// R4: bit 15 clear uses reference clock, set uses the clock multiplier.
// R5: bits 14:13 pick oscillator-to-sample ratio 1, 2, 4 or 8.
// R6: bits 12:11 pick sample-to-reference ratio 2, 4, 8 or 16.
// R7: bits 10:8 set oscillator bias current; 011 recommended.
// R8: bits 7:2 select oscillator band and go to the oscillator.
// R9: bits 1:0 set oscillator output drive; 11 recommended.
// R10: converter control registers are two bytes, routed straight to periphery.
// R11: I sleep bit 15, default zero active, set means low power.
// R12: I power-down bit 14, default zero active, set means low power.
// R13: I register bits 9:0 carry gain; bits 13:10 reserved.
// R14: aux one sign bit 15 selects positive or negative output pin.
// R15: aux one bit 14: zero sources current, one sinks current.
// R16: aux one power-down bit 13, default zero active, set low power.
// R17: aux one bits 9:0 carry gain; bits 12:10 reserved.
// R18: Q sleep bit 15, default zero active, set means low power.
// R19: Q power-down bit 14, default zero active, set means low power.
// R20: Q register bits 9:0 carry gain for the Q converter.
// R21: reserved bits read as zero and ignore writes.
`timescale 1ns/100ps
`include "pdc_regs.svh"

module pdc_regbank
  import pdc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  // register access from the serial control port
  input  wire logic [ADDR_W-1:0] acc_addr_in,
  input  wire logic              acc_wr_in,
  input  wire logic              acc_rd_in,
  input  wire logic [23:0]       acc_wdata_in,
  output logic      [23:0]       acc_rdata_out,
  output logic                   acc_rvalid_out,
  output logic                   acc_err_out,
  // analog oscillator control voltage code, asynchronous
  input  wire logic [2:0]        vco_volt_code_in,
  // clock multiplier periphery
  output logic                   vco_volt_centred_out,
  output logic [4:0]             loop_bw_out,
  output logic                   mult_enable_out,
  output logic                   sample_clk_from_mult_out,
  output logic [1:0]             vco_div_out,
  output logic [1:0]             loop_div_out,
  output logic [2:0]             vco_bias_out,
  output logic [5:0]             vco_band_out,
  output logic [1:0]             vco_drive_out,
  // I converter periphery
  output logic                   iconv_sleep_out,
  output logic                   iconv_pdown_out,
  output logic [9:0]             iconv_gain_out,
  // auxiliary converter one periphery
  output logic                   aux1_sign_neg_out,
  output logic                   aux1_sink_out,
  output logic                   aux1_pdown_out,
  output logic [9:0]             aux1_gain_out,
  // Q converter periphery
  output logic                   qconv_sleep_out,
  output logic                   qconv_pdown_out,
  output logic [9:0]             qconv_gain_out
);

  // ============================================================
  // reset release
  logic rst_meta_q;
  logic rst_sync_n_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q   <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q   <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // ============================================================
  // oscillator voltage code synchroniser
  // analog comparator outputs change at any time, so two stages first
  logic [2:0] vcov_meta_q;
  logic [2:0] vcov_sync_q;
  logic [2:0] vcov_q;

  always_ff @(posedge clk_sys_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      vcov_meta_q <= 3'h0;
      vcov_sync_q <= 3'h0;
    end else if (ce_in) begin
      vcov_meta_q <= vco_volt_code_in;
      vcov_sync_q <= vcov_meta_q;
    end
  end

  // R2: voltage code capture
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      vcov_q <= 3'h0;
    end else if (ce_in) begin
      vcov_q <= vcov_sync_q;
    end
  end

  // ============================================================
  // address decode
  pdc_sel_t sel;
  logic     hit_mult;
  logic     hit_iconv;
  logic     hit_aux1;
  logic     hit_qconv;
  logic     hit_any;
  logic     wr_go;
  logic     rd_go;

  assign hit_mult  = (acc_addr_in == ADDR_W'(`PDC_ADDR_MULT));
  assign hit_iconv = (acc_addr_in == ADDR_W'(`PDC_ADDR_ICONV));
  assign hit_aux1  = (acc_addr_in == ADDR_W'(`PDC_ADDR_AUX1));
  assign hit_qconv = (acc_addr_in == ADDR_W'(`PDC_ADDR_QCONV));
  assign hit_any   = hit_mult | hit_iconv | hit_aux1 | hit_qconv;
  assign sel       = hit_mult  ? PDC_SEL_MULT  :
                     hit_iconv ? PDC_SEL_ICONV :
                     hit_aux1  ? PDC_SEL_AUX1  :
                     hit_qconv ? PDC_SEL_QCONV : PDC_SEL_NONE;
  assign wr_go     = ce_in & acc_wr_in;
  assign rd_go     = ce_in & acc_rd_in;

  // ============================================================
  // register storage
  logic [`PDC_MULT_W-1:0] mult_q;
  logic [`PDC_MULT_W-1:0] mult_d;
  logic [`PDC_CONV_W-1:0] iconv_q;
  logic [`PDC_CONV_W-1:0] iconv_d;
  logic [`PDC_CONV_W-1:0] aux1_q;
  logic [`PDC_CONV_W-1:0] aux1_d;
  logic [`PDC_CONV_W-1:0] qconv_q;
  logic [`PDC_CONV_W-1:0] qconv_d;

  // R1: three-byte word, voltage code bits never stored
  // R21: masks drop reserved and read-only bits
  assign mult_d  = acc_wdata_in & `PDC_MC_WR_MASK;
  // R10: two-byte words from the low lanes
  assign iconv_d = acc_wdata_in[`PDC_CONV_W-1:0] & `PDC_CV_WR_MASK;
  assign aux1_d  = acc_wdata_in[`PDC_CONV_W-1:0] & `PDC_AX_WR_MASK;
  assign qconv_d = acc_wdata_in[`PDC_CONV_W-1:0] & `PDC_CV_WR_MASK;

  always_ff @(posedge clk_sys_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      mult_q <= `PDC_MULT_RST;
    end else if (wr_go && hit_mult) begin
      mult_q <= mult_d;
    end
  end

  // R11: sleep and power-down default to zero, converter active
  // R12: power-down bit stored as written
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      iconv_q <= `PDC_CONV_RST;
    end else if (wr_go && hit_iconv) begin
      iconv_q <= iconv_d;
    end
  end

  // R14: sign, direction and power-down reset to zero
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      aux1_q <= `PDC_CONV_RST;
    end else if (wr_go && hit_aux1) begin
      aux1_q <= aux1_d;
    end
  end

  // R18: Q sleep and power-down default to zero
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      qconv_q <= `PDC_CONV_RST;
    end else if (wr_go && hit_qconv) begin
      qconv_q <= qconv_d;
    end
  end

  // ============================================================
  // readback
  logic [23:0] rd_mux;
  logic [23:0] mult_rd;
  logic        centred;

  // R2: live code in the top bits of the multiplier word
  assign mult_rd = {vcov_q, mult_q[`PDC_MC_LBW_HI:0]};
  assign centred = (vcov_q == `PDC_VCOV_CENTRE);

  // R21: stored reserved bits are zero, so readback shows zero there
  always_comb begin
    rd_mux = 24'h00_0000;
    unique case (sel)
      PDC_SEL_NONE:  rd_mux = 24'h00_0000;
      PDC_SEL_MULT:  rd_mux = mult_rd;
      PDC_SEL_ICONV: rd_mux = {8'h00, iconv_q};
      PDC_SEL_AUX1:  rd_mux = {8'h00, aux1_q};
      PDC_SEL_QCONV: rd_mux = {8'h00, qconv_q};
      default:       rd_mux = 24'h00_0000;
    endcase
  end

  // unmapped reads return zero with an error pulse
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      acc_rdata_out  <= 24'h00_0000;
      acc_rvalid_out <= 1'b0;
      acc_err_out    <= 1'b0;
    end else if (ce_in) begin
      acc_rvalid_out <= acc_rd_in;
      acc_err_out    <= (acc_rd_in | acc_wr_in) & ~hit_any;
      if (rd_go) begin
        acc_rdata_out <= rd_mux;
      end
    end
  end

  // ============================================================
  // centred flag to the periphery
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      vco_volt_centred_out <= 1'b0;
    end else if (ce_in) begin
      // R2: centre code flagged
      vco_volt_centred_out <= centred;
    end
  end

  // ============================================================
  // clock multiplier periphery, straight from the register
  // R3: bandwidth code to the loop filter
  assign loop_bw_out              = mult_q[`PDC_MC_LBW_HI:`PDC_MC_LBW_LO];
  // R4: clock source select, reference clock when clear
  assign mult_enable_out          = mult_q[`PDC_MC_EN_BIT];
  assign sample_clk_from_mult_out = mult_q[`PDC_MC_EN_BIT];
  // R5: oscillator output divider code
  assign vco_div_out              = mult_q[`PDC_MC_VDIV_HI:`PDC_MC_VDIV_LO];
  // R6: loop divider code
  assign loop_div_out             = mult_q[`PDC_MC_LDIV_HI:`PDC_MC_LDIV_LO];
  // R7: bias current code
  assign vco_bias_out             = mult_q[`PDC_MC_BIAS_HI:`PDC_MC_BIAS_LO];
  // R8: band select to the oscillator
  assign vco_band_out             = mult_q[`PDC_MC_BAND_HI:`PDC_MC_BAND_LO];
  // R9: output drive strength
  assign vco_drive_out            = mult_q[`PDC_MC_DRV_HI:`PDC_MC_DRV_LO];

  // ============================================================
  // I converter periphery
  // R11: sleep control
  assign iconv_sleep_out = iconv_q[`PDC_CV_SLEEP_BIT];
  // R12: power-down control
  assign iconv_pdown_out = iconv_q[`PDC_CV_PD_BIT];
  // R13: gain adjustment
  assign iconv_gain_out  = iconv_q[`PDC_CV_GAIN_HI:`PDC_CV_GAIN_LO];

  // ============================================================
  // auxiliary converter one periphery
  // R14: negative sign moves output to the alternate pin
  assign aux1_sign_neg_out = aux1_q[`PDC_AX_SIGN_BIT];
  // R15: sink when set
  assign aux1_sink_out     = aux1_q[`PDC_AX_DIR_BIT];
  // R16: power-down control
  assign aux1_pdown_out    = aux1_q[`PDC_AX_PD_BIT];
  // R17: gain adjustment
  assign aux1_gain_out     = aux1_q[`PDC_CV_GAIN_HI:`PDC_CV_GAIN_LO];

  // ============================================================
  // Q converter periphery
  // R18: sleep control
  assign qconv_sleep_out = qconv_q[`PDC_CV_SLEEP_BIT];
  // R19: power-down control
  assign qconv_pdown_out = qconv_q[`PDC_CV_PD_BIT];
  // R20: gain adjustment
  assign qconv_gain_out  = qconv_q[`PDC_CV_GAIN_HI:`PDC_CV_GAIN_LO];

endmodule

// ---- design/pdc_regs.svh ----
// Purpose: addresses, field positions and reset values of the converter control bank
// Assumes: byte-addressed serial control port, one address per register
// Notes:   definitions only
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

// ============================================================
// register addresses
`define PDC_ADDR_MULT     8'h04
`define PDC_ADDR_ICONV    8'h05
`define PDC_ADDR_AUX1     8'h06
`define PDC_ADDR_QCONV    8'h07

// ============================================================
// register widths and reset values
`define PDC_MULT_W        24
`define PDC_CONV_W        16
`define PDC_MULT_RST      24'h00_0000
`define PDC_CONV_RST      16'h0000

// ============================================================
// clock multiplier fields
`define PDC_MC_VCOV_HI    23
`define PDC_MC_VCOV_LO    21
`define PDC_MC_LBW_HI     20
`define PDC_MC_LBW_LO     16
`define PDC_MC_EN_BIT     15
`define PDC_MC_VDIV_HI    14
`define PDC_MC_VDIV_LO    13
`define PDC_MC_LDIV_HI    12
`define PDC_MC_LDIV_LO    11
`define PDC_MC_BIAS_HI    10
`define PDC_MC_BIAS_LO    8
`define PDC_MC_BAND_HI    7
`define PDC_MC_BAND_LO    2
`define PDC_MC_DRV_HI     1
`define PDC_MC_DRV_LO     0
// writable bits of the multiplier word; the voltage code is read only
`define PDC_MC_WR_MASK    24'h1F_FFFF
// code reported when the oscillator control voltage sits mid range
`define PDC_VCOV_CENTRE   3'h3

// ============================================================
// converter control fields
`define PDC_CV_SLEEP_BIT  15
`define PDC_CV_PD_BIT     14
`define PDC_AX_SIGN_BIT   15
`define PDC_AX_DIR_BIT    14
`define PDC_AX_PD_BIT     13
`define PDC_CV_GAIN_HI    9
`define PDC_CV_GAIN_LO    0
// implemented bits; reserved bits are dropped on write and read as zero
`define PDC_CV_WR_MASK    16'hC3FF
`define PDC_AX_WR_MASK    16'hE3FF

`endif

// ---- design/pdc_pkg.sv ----
// Purpose: shared types of the converter control bank
// Assumes: constants live in pdc_regs.svh
// Notes:   types only
package pdc_pkg;

  // ============================================================
  // register select decoded from the access address
  typedef enum logic [2:0] {
    PDC_SEL_NONE  = 3'b000,
    PDC_SEL_MULT  = 3'b001,
    PDC_SEL_ICONV = 3'b010,
    PDC_SEL_AUX1  = 3'b011,
    PDC_SEL_QCONV = 3'b100
  } pdc_sel_t;

  typedef logic [23:0] pdc_word_t;
  typedef logic [15:0] pdc_half_t;

endpackage

// ---- verification/pdc_regbank_sva.sv ----
// Purpose: port assertions for the converter control bank
// Assumes: one clock domain, reset on rst_n_in
// Notes:   bound from the testbench top file
`timescale 1ns/100ps
module pdc_regbank_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk_sys_in, rst_n_in, ce_in, acc_wr_in, acc_rd_in,
  input wire logic [ADDR_W-1:0] acc_addr_in,
  input wire logic [23:0]       acc_wdata_in, acc_rdata_out,
  input wire logic [2:0]        vco_volt_code_in, vco_bias_out,
  input wire logic              acc_rvalid_out, acc_err_out, vco_volt_centred_out,
  input wire logic              mult_enable_out, sample_clk_from_mult_out,
  input wire logic [4:0]        loop_bw_out,
  input wire logic [1:0]        vco_div_out, loop_div_out, vco_drive_out,
  input wire logic [5:0]        vco_band_out,
  input wire logic              iconv_sleep_out, iconv_pdown_out, qconv_sleep_out, qconv_pdown_out,
  input wire logic              aux1_sign_neg_out, aux1_sink_out, aux1_pdown_out,
  input wire logic [9:0]        iconv_gain_out, aux1_gain_out, qconv_gain_out
);
  // ============================================================
  // taken accesses
  wire logic tk_wr = ce_in && acc_wr_in;
  wire logic tk_rd = ce_in && acc_rd_in;
  wire logic unmap = acc_addr_in < ADDR_W'(4) || acc_addr_in > ADDR_W'(7);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ============================================================
  // assertions
  a_mult_fields: assert property (tk_wr && acc_addr_in == ADDR_W'(4) |=>
    {loop_bw_out, mult_enable_out, vco_div_out, loop_div_out, vco_bias_out, vco_band_out, vco_drive_out}
    == $past(acc_wdata_in[20:0])) else $error("multiplier fields differ from write");
  a_clk_source: assert property (sample_clk_from_mult_out == mult_enable_out)
    else $error("sample clock source differs from enable");
  a_iconv_fields: assert property (tk_wr && acc_addr_in == ADDR_W'(5) |=>
    {iconv_sleep_out, iconv_pdown_out, iconv_gain_out} == {$past(acc_wdata_in[15:14]), $past(acc_wdata_in[9:0])})
    else $error("I converter fields differ from write");
  a_aux1_fields: assert property (tk_wr && acc_addr_in == ADDR_W'(6) |=>
    {aux1_sign_neg_out, aux1_sink_out, aux1_pdown_out, aux1_gain_out} == {$past(acc_wdata_in[15:13]),
    $past(acc_wdata_in[9:0])}) else $error("aux converter fields differ from write");
  a_qconv_fields: assert property (tk_wr && acc_addr_in == ADDR_W'(7) |=>
    {qconv_sleep_out, qconv_pdown_out, qconv_gain_out} == {$past(acc_wdata_in[15:14]), $past(acc_wdata_in[9:0])})
    else $error("Q converter fields differ from write");
  a_read_answer: assert property (tk_rd |=> acc_rvalid_out) else $error("read not answered");
  a_unmapped_err: assert property ((tk_rd || tk_wr) && unmap |=> acc_err_out) else $error("no error flag");
  a_rsv_zero: assert property (acc_rvalid_out && $past(acc_addr_in) == ADDR_W'(5) |->
    acc_rdata_out[13:10] == 4'h0) else $error("reserved bits read nonzero");
  a_centred_on: assert property ((ce_in && vco_volt_code_in == 3'b011)[*8] |-> vco_volt_centred_out)
    else $error("centred flag missing");
  a_centred_off: assert property ((ce_in && vco_volt_code_in != 3'b011)[*8] |-> !vco_volt_centred_out)
    else $error("centred flag stuck");
  cover property (tk_wr && acc_addr_in == ADDR_W'(4));
  cover property (acc_rvalid_out && acc_err_out);
  cover property (vco_volt_centred_out);
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the converter control bank
// Assumes: strobes driven 1 ns after the rising edge
// Notes:   one access at a time, one idle cycle between
`timescale 1ns/100ps
module testbench;
  logic        clk_sys_in, rst_n_in, ce_in, acc_wr_in, acc_rd_in, acc_rvalid_out, acc_err_out;
  logic [7:0]  acc_addr_in;
  logic [23:0] acc_wdata_in, acc_rdata_out;
  logic [2:0]  vco_volt_code_in, vco_bias_out;
  logic        vco_volt_centred_out, mult_enable_out, sample_clk_from_mult_out;
  logic [4:0]  loop_bw_out;
  logic [1:0]  vco_div_out, loop_div_out, vco_drive_out;
  logic [5:0]  vco_band_out;
  logic        iconv_sleep_out, iconv_pdown_out, qconv_sleep_out, qconv_pdown_out;
  logic        aux1_sign_neg_out, aux1_sink_out, aux1_pdown_out;
  logic [9:0]  iconv_gain_out, aux1_gain_out, qconv_gain_out;
  int          n_fail = 0, checked = 0, cyc = 0;
  pdc_regbank pdc_regbank_inst (.clk_sys_in, .rst_n_in, .ce_in, .acc_addr_in, .acc_wr_in, .acc_rd_in,
    .acc_wdata_in, .acc_rdata_out, .acc_rvalid_out, .acc_err_out, .vco_volt_code_in, .vco_volt_centred_out,
    .loop_bw_out, .mult_enable_out, .sample_clk_from_mult_out, .vco_div_out, .loop_div_out, .vco_bias_out,
    .vco_band_out, .vco_drive_out, .iconv_sleep_out, .iconv_pdown_out, .iconv_gain_out, .aux1_sign_neg_out,
    .aux1_sink_out, .aux1_pdown_out, .aux1_gain_out, .qconv_sleep_out, .qconv_pdown_out, .qconv_gain_out);
  // ============================================================
  // shared tasks
  task automatic close_out();
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobe stays one cycle; idle edge before it keeps drivers single per step
  task automatic acc(input logic wr, input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_sys_in);
    #1;
    {acc_addr_in, acc_wdata_in, acc_wr_in, acc_rd_in} = {a, d, wr, !wr};
    @(posedge clk_sys_in);
    #1;
    {acc_wr_in, acc_rd_in} = 2'b00;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [23:0] exp);
    acc(0, a, 24'h00_0000);
    chk("read", {acc_rvalid_out, acc_err_out, acc_rdata_out}, {2'b10, exp});
  endtask
  // ============================================================
  // scenarios
  task automatic t_reset();
    chk("idle", {mult_enable_out, iconv_sleep_out, iconv_pdown_out, aux1_sign_neg_out, aux1_sink_out,
      aux1_pdown_out, qconv_sleep_out, qconv_pdown_out}, 0);
    for (int a = 4; a < 8; a++) rdchk(8'(a), 24'h00_0000);
  endtask
  task automatic t_mult();
    logic [23:0] d;
    vco_volt_code_in = 3'b101;
    for (int i = 0; i < 4; i++) begin
      d = {3'b111, 5'(15 + i), i[0], i[1:0], 2'(3 - i), 3'(i), 6'(21 * i), 2'(i)};
      acc(1, 8'h04, d);
      chk("mult", {loop_bw_out, mult_enable_out, sample_clk_from_mult_out}, {d[20:15], d[15]});
      chk("div", {vco_div_out, loop_div_out}, d[14:11]);
      chk("vco", {vco_bias_out, vco_band_out, vco_drive_out}, d[10:0]);
      rdchk(8'h04, {3'b101, d[20:0]});
    end
  endtask
  task automatic t_conv();
    logic [15:0] d;
    for (int k = 0; k < 6; k++) begin
      d = (k < 3) ? 16'hFFFF : 16'h4A55;
      acc(1, 8'(5 + k % 3), {8'h00, d});
      case (k % 3)
        0: chk("iconv", {iconv_sleep_out, iconv_pdown_out, iconv_gain_out}, {d[15:14], d[9:0]});
        1: chk("aux1", {aux1_sign_neg_out, aux1_sink_out, aux1_pdown_out, aux1_gain_out}, {d[15:13], d[9:0]});
        default: chk("qconv", {qconv_sleep_out, qconv_pdown_out, qconv_gain_out}, {d[15:14], d[9:0]});
      endcase
      rdchk(8'(5 + k % 3), {8'h00, d & ((k % 3 == 1) ? 16'hE3FF : 16'hC3FF)});
    end
  endtask
  task automatic t_err();
    acc(0, 8'h08, 24'h00_0000);
    chk("unmapped rd", {acc_rvalid_out, acc_err_out, acc_rdata_out}, {2'b11, 24'h00_0000});
    acc(1, 8'h03, 24'hFF_FFFF);
    chk("unmapped wr", acc_err_out, 1);
    rdchk(8'h05, 24'h00_4A55 & 24'h00_C3FF);
  endtask
  task automatic t_ce();
    ce_in = 0;
    acc(1, 8'h05, 24'h00_0000);
    ce_in = 1;
    chk("frozen", {iconv_sleep_out, iconv_pdown_out, iconv_gain_out}, {2'b01, 10'h255});
  endtask
  task automatic t_centred();
    vco_volt_code_in = 3'b011;
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk("centred", vco_volt_centred_out, 1);
    vco_volt_code_in = 3'b010;
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk("off centre", vco_volt_centred_out, 0);
  endtask
  // ============================================================
  // clock, watchdog, main sequence
  initial begin
    clk_sys_in = 0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    {rst_n_in, acc_wr_in, acc_rd_in, acc_addr_in, acc_wdata_in, vco_volt_code_in} = 0;
    ce_in = 1;
    repeat (10) @(posedge clk_sys_in);
    #1;
    rst_n_in = 1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    t_reset();
    t_mult();
    t_conv();
    t_err();
    t_ce();
    t_centred();
    close_out();
  end
endmodule

bind pdc_regbank pdc_regbank_sva #(.ADDR_W(ADDR_W)) pdc_regbank_sva_inst (.clk_sys_in, .rst_n_in, .ce_in,
  .acc_wr_in, .acc_rd_in, .acc_addr_in, .acc_wdata_in, .acc_rdata_out, .vco_volt_code_in, .vco_bias_out,
  .acc_rvalid_out, .acc_err_out, .vco_volt_centred_out, .mult_enable_out, .sample_clk_from_mult_out,
  .loop_bw_out, .vco_div_out, .loop_div_out, .vco_drive_out, .vco_band_out, .iconv_sleep_out,
  .iconv_pdown_out, .qconv_sleep_out, .qconv_pdown_out, .aux1_sign_neg_out, .aux1_sink_out, .aux1_pdown_out,
  .iconv_gain_out, .aux1_gain_out, .qconv_gain_out);
